// ==== rtl/icc_pkg.sv ====
package icc_pkg;
   // Register map of the chop-control block
   localparam logic [7:0] ICC_SLOT_A_POLARITY_ADDR = 8'h17;
   localparam logic [7:0] ICC_SLOT_B_POLARITY_ADDR = 8'h1d;
   localparam logic [7:0] ICC_SIGN_MATH_ADDR = 8'h58;
   localparam int ICC_REG_W = 16;
   localparam logic [15:0] ICC_REG_RESET = 16'h0000;

   // Field positions
   localparam int ICC_POLARITY_LSB = 0;
   localparam int ICC_A_FIRST_SECOND_LSB = 1;
   localparam int ICC_B_FIRST_SECOND_LSB = 5;
   localparam int ICC_A_THIRD_FOURTH_LSB = 8;
   localparam int ICC_B_THIRD_FOURTH_LSB = 10;

   // Pulses in one repeating group
   localparam int ICC_GROUP_LEN = 4;

   // Slot codes on the slot select input
   localparam logic ICC_SLOT_A = 1'b0;
   localparam logic ICC_SLOT_B = 1'b1;

   // Sample sequencing states
   typedef enum logic [1:0]
   {
      ICC_IDLE = 2'b01,
      ICC_RUN = 2'b10
   } icc_state_t;

   // Per-slot chop settings: bit n of each field is pulse n+1 of a group
   typedef struct packed
   {
      logic [3:0] reverse;
      logic [3:0] subtract;
   } icc_slot_cfg_t;

   // Register access request
   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [15:0] wdata;
   } icc_reg_req_t;
endpackage

// ==== rtl/icc_chop_control.sv ====
`timescale 1ns/1ps
module icc_chop_control
   import icc_pkg::*;
#(
   parameter int DATA_W = 14,
   parameter int ACC_W = 20
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata_reg,
   output logic reg_rvalid_reg,
   input wire logic sample_start,
   input wire logic sample_slot,
   input wire logic pulse_done,
   input wire logic [DATA_W-1:0] pulse_data,
   input wire logic sample_end,
   output logic integ_reverse_reg,
   output logic [1:0] pulse_pos_reg,
   output logic signed [ACC_W-1:0] sample_sum_reg,
   output logic sample_valid_reg,
   output logic sample_slot_reg,
   output logic busy_reg
);

   // Elaboration check: the sum needs headroom above a single pulse result
   if (DATA_W < 1 || ACC_W <= DATA_W)
   begin
      $error("icc_chop_control: ACC_W must exceed DATA_W");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   icc_reg_req_t req;
   logic [15:0] slot_a_pulse_polarity_reg;
   logic [15:0] slot_b_pulse_polarity_reg;
   logic [15:0] pulse_sign_math_control_reg;

   assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

   // Full 16-bit words are kept so software reads back what it wrote
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         slot_a_pulse_polarity_reg <= ICC_REG_RESET;
         slot_b_pulse_polarity_reg <= ICC_REG_RESET;
         pulse_sign_math_control_reg <= ICC_REG_RESET;
      end
      else if (req.wr)
      begin
         case (req.addr)
            ICC_SLOT_A_POLARITY_ADDR: slot_a_pulse_polarity_reg <= req.wdata;
            ICC_SLOT_B_POLARITY_ADDR: slot_b_pulse_polarity_reg <= req.wdata;
            ICC_SIGN_MATH_ADDR: pulse_sign_math_control_reg <= req.wdata;
            default: ;
         endcase
      end
   end

   // Read answer one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reg_rdata_reg <= 16'h0000;
         reg_rvalid_reg <= 1'b0;
      end
      else
      begin
         reg_rvalid_reg <= req.rd;
         if (req.rd)
         begin
            case (req.addr)
               ICC_SLOT_A_POLARITY_ADDR: reg_rdata_reg <= slot_a_pulse_polarity_reg;
               ICC_SLOT_B_POLARITY_ADDR: reg_rdata_reg <= slot_b_pulse_polarity_reg;
               ICC_SIGN_MATH_ADDR: reg_rdata_reg <= pulse_sign_math_control_reg;
               default: reg_rdata_reg <= 16'h0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-slot settings, unpacked into pulse order

   icc_slot_cfg_t cfg_a;
   icc_slot_cfg_t cfg_b;
   icc_slot_cfg_t cfg_cur;

   // Each slot has its own unpacker fed only by its own fields, so one slot's
   // settings cannot leak into the other slot's masks
   icc_slot_unpack #(
      .POL_LSB(ICC_POLARITY_LSB),
      .SIGN12_LSB(ICC_A_FIRST_SECOND_LSB),
      .SIGN34_LSB(ICC_A_THIRD_FOURTH_LSB)
   )
   u_unpack_a
   (
      .polarity_word(slot_a_pulse_polarity_reg),
      .math_word(pulse_sign_math_control_reg),
      .cfg(cfg_a)
   );

   icc_slot_unpack #(
      .POL_LSB(ICC_POLARITY_LSB),
      .SIGN12_LSB(ICC_B_FIRST_SECOND_LSB),
      .SIGN34_LSB(ICC_B_THIRD_FOURTH_LSB)
   )
   u_unpack_b
   (
      .polarity_word(slot_b_pulse_polarity_reg),
      .math_word(pulse_sign_math_control_reg),
      .cfg(cfg_b)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sample sequencing

   icc_state_t state_reg;
   logic slot_reg;
   logic [1:0] pos_next;

   // The running sample only ever looks at its own slot's settings
   assign cfg_cur = (slot_reg == ICC_SLOT_B) ? cfg_b : cfg_a;
   assign pos_next = pulse_pos_reg + 2'd1;

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_reg <= ICC_IDLE;
         slot_reg <= ICC_SLOT_A;
      end
      else
      begin
         case (state_reg)
            ICC_IDLE:
            begin
               if (sample_start)
               begin
                  state_reg <= ICC_RUN;
                  slot_reg <= sample_slot;
               end
            end
            ICC_RUN:
            begin
               if (sample_end)
               begin
                  state_reg <= ICC_IDLE;
               end
            end
            default: state_reg <= ICC_IDLE;
         endcase
      end
   end

   // Position in the four-pulse group and polarity for the coming pulse
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pulse_pos_reg <= 2'd0;
         integ_reverse_reg <= 1'b0;
         busy_reg <= 1'b0;
      end
      else if (state_reg == ICC_IDLE && sample_start)
      begin
         pulse_pos_reg <= 2'd0;
         busy_reg <= 1'b1;
         if (sample_slot == ICC_SLOT_B)
         begin
            integ_reverse_reg <= cfg_b.reverse[0];
         end
         else
         begin
            integ_reverse_reg <= cfg_a.reverse[0];
         end
      end
      else if (state_reg == ICC_RUN && sample_end)
      begin
         busy_reg <= 1'b0;
         integ_reverse_reg <= 1'b0;
         pulse_pos_reg <= 2'd0;
      end
      else if (state_reg == ICC_RUN && pulse_done)
      begin
         pulse_pos_reg <= pos_next;
         integ_reverse_reg <= cfg_cur.reverse[pos_next];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Signed accumulation of pulse results

   logic signed [ACC_W-1:0] acc_reg;
   logic signed [ACC_W-1:0] term;

   // Zero-extended result, negated for positions marked subtract
   assign term = cfg_cur.subtract[pulse_pos_reg]
      ? -$signed({{(ACC_W-DATA_W){1'b0}}, pulse_data})
      : $signed({{(ACC_W-DATA_W){1'b0}}, pulse_data});

   // Wraps on overflow; the caller sizes ACC_W for its largest pulse count
   // A pulse that lands on the end cycle is dropped, so the sum covers only earlier pulses
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         acc_reg <= '0;
      end
      else if (state_reg == ICC_IDLE && sample_start)
      begin
         acc_reg <= '0;
      end
      else if (state_reg == ICC_RUN && pulse_done && !sample_end)
      begin
         acc_reg <= acc_reg + term;
      end
   end

   // Finished sample, tagged with its slot, shown for one cycle of valid
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sample_sum_reg <= '0;
         sample_valid_reg <= 1'b0;
         sample_slot_reg <= ICC_SLOT_A;
      end
      else
      begin
         sample_valid_reg <= 1'b0;
         if (state_reg == ICC_RUN && sample_end)
         begin
            sample_sum_reg <= acc_reg;
            sample_valid_reg <= 1'b1;
            sample_slot_reg <= slot_reg;
         end
      end
   end

endmodule

////////////////////////////////////////////////////////////////////////////////
// One slot's fields turned into pulse-ordered masks; bit n of a mask is pulse n+1
module icc_slot_unpack
   import icc_pkg::*;
#(
   parameter int POL_LSB = ICC_POLARITY_LSB,
   parameter int SIGN12_LSB = ICC_A_FIRST_SECOND_LSB,
   parameter int SIGN34_LSB = ICC_A_THIRD_FOURTH_LSB
)
(
   input wire logic [15:0] polarity_word,
   input wire logic [15:0] math_word,
   output icc_slot_cfg_t cfg
);

   logic [1:0] first_second;
   logic [1:0] third_fourth;
   logic [3:0] reverse_mask;
   logic [3:0] subtract_mask;

   // Elaboration check: every field must sit inside its 16-bit register
   if (POL_LSB < 0 || POL_LSB + ICC_GROUP_LEN > ICC_REG_W || SIGN12_LSB < 0 || SIGN12_LSB + 2 > ICC_REG_W
      || SIGN34_LSB < 0 || SIGN34_LSB + 2 > ICC_REG_W)
   begin
      $error("icc_slot_unpack: field position outside the register");
   end

   // Two-bit sign codes of the two pulse pairs
   assign first_second = math_word[SIGN12_LSB +: 2];
   assign third_fourth = math_word[SIGN34_LSB +: 2];

   // A one selects the reversed integration sequence for that pulse, a zero the normal one
   assign reverse_mask = polarity_word[POL_LSB +: ICC_GROUP_LEN];

   // The upper code bit signs the earlier pulse of a pair and the lower bit the later one,
   // so code 01 adds the earlier pulse and subtracts the later
   assign subtract_mask = {third_fourth[0], third_fourth[1], first_second[0], first_second[1]};

   // One assignment for the whole struct keeps a single driver on the output
   assign cfg = '{reverse: reverse_mask, subtract: subtract_mask};
endmodule

// ==== testbench/icc_chop_control_assertions.sv ====
`timescale 1ns/1ps
module icc_chop_control_assertions
   import icc_pkg::*;
#(
   parameter int DATA_W = 14,
   parameter int ACC_W = 20
)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic reg_rd,
   input wire logic reg_rvalid_reg,
   input wire logic sample_start,
   input wire logic pulse_done,
   input wire logic sample_end,
   input wire logic integ_reverse_reg,
   input wire logic [1:0] pulse_pos_reg,
   input wire logic signed [ACC_W-1:0] sample_sum_reg,
   input wire logic sample_valid_reg,
   input wire logic busy_reg
);
   ////////////////////////////////////////////////////////////////////////////
   // One clock domain, so clocking and reset are given once
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_start_first_pulse: assert property (sample_start && !busy_reg |=> busy_reg && pulse_pos_reg == 2'd0)
      else $error("start did not open at pulse one");
   a_pulse_advance: assert property (pulse_done && busy_reg && !sample_end |=> pulse_pos_reg == $past(pulse_pos_reg) + 2'd1)
      else $error("pulse position did not advance");
   a_pos_hold: assert property (busy_reg && !pulse_done && !sample_end |=> $stable(pulse_pos_reg))
      else $error("pulse position moved without a pulse");
   a_end_result: assert property (sample_end && busy_reg |=> sample_valid_reg && !busy_reg)
      else $error("sample end gave no result");
   a_valid_single: assert property (sample_valid_reg |=> !sample_valid_reg)
      else $error("result valid longer than one cycle");
   a_sum_holds: assert property (!sample_valid_reg |-> $stable(sample_sum_reg))
      else $error("sum changed without a result");
   a_idle_normal: assert property (!busy_reg |-> !integ_reverse_reg && pulse_pos_reg == 2'd0)
      else $error("idle integrator not normal");
   a_read_answer: assert property (reg_rd |=> reg_rvalid_reg)
      else $error("read not answered");
   a_no_stray_answer: assert property (!reg_rd |=> !reg_rvalid_reg)
      else $error("answer without a read");
endmodule

// ==== testbench/test_icc_chop_control.sv ====
`timescale 1ns/1ps
module test_icc_chop_control;
   import icc_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sample_start = 1'b0;
   logic sample_slot = 1'b0;
   logic pulse_done = 1'b0;
   logic sample_end = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic [13:0] pulse_data = 14'h0000;
   logic [15:0] reg_rdata_reg;
   logic reg_rvalid_reg;
   logic integ_reverse_reg;
   logic sample_valid_reg;
   logic sample_slot_reg;
   logic busy_reg;
   logic [1:0] pulse_pos_reg;
   logic signed [19:0] sample_sum_reg;
   logic [15:0] pa = 16'h0000;
   logic [15:0] pb = 16'h0000;
   logic [15:0] pm = 16'h0000;
   logic [31:0] seed = 32'h2c441166;
   logic [15:0] exp_rd[$];
   logic [20:0] exp_sum[$];
   logic [2:0] exp_pat[$];
   int errors = 0;
   int total_checks = 0;
   int i;

   always #20 clock = ~clock;

   icc_chop_control u_dut (.clock, .reset_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata_reg, .reg_rvalid_reg,
      .sample_start, .sample_slot, .pulse_done, .pulse_data, .sample_end, .integ_reverse_reg, .pulse_pos_reg,
      .sample_sum_reg, .sample_valid_reg, .sample_slot_reg, .busy_reg);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers; shadow copies of the registers give the expected values
   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1)
      begin
         errors++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask

   task test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      if (a == ICC_SLOT_A_POLARITY_ADDR) pa = d;
      if (a == ICC_SLOT_B_POLARITY_ADDR) pb = d;
      if (a == ICC_SIGN_MATH_ADDR) pm = d;
   endtask

   // Unmapped places read back as zero
   task rd(input logic [7:0] a);
      exp_rd.push_back(a == ICC_SLOT_A_POLARITY_ADDR ? pa : a == ICC_SLOT_B_POLARITY_ADDR ? pb :
         a == ICC_SIGN_MATH_ADDR ? pm : 16'h0000);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask

   // One sample of n pulses; a pulse on the end cycle must be dropped
   task run(input logic s, input int n);
      logic [19:0] acc;
      logic [3:0] rev;
      logic [3:0] sub;
      int k;
      acc = 20'h00000;
      rev = s ? pb[3:0] : pa[3:0];
      sub = s ? {pm[10], pm[11], pm[5], pm[6]} : {pm[8], pm[9], pm[1], pm[2]};
      @(posedge clock);
      sample_start <= 1'b1;
      sample_slot <= s;
      for (k = 0; k < n; k++)
      begin
         @(posedge clock);
         sample_start <= 1'b0;
         seed = lfsr(seed);
         pulse_done <= 1'b1;
         pulse_data <= seed[13:0];
         acc = sub[k%4] ? acc - 20'(seed[13:0]) : acc + 20'(seed[13:0]);
         exp_pat.push_back({2'(k % 4), rev[k%4]});
      end
      @(posedge clock);
      sample_end <= 1'b1;
      exp_sum.push_back({s, acc});
      @(posedge clock);
      pulse_done <= 1'b0;
      sample_end <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Result watcher takes the oldest note at each answer
   always @(posedge clock)
   begin
      #2;
      if (reg_rvalid_reg === 1'b1)
         check(exp_rd.size() > 0 && reg_rdata_reg === exp_rd.pop_front(), "read data");
      if (sample_valid_reg === 1'b1)
         check(exp_sum.size() > 0 && {sample_slot_reg, sample_sum_reg} === exp_sum.pop_front(),
            "sample sum");
      // Each accepted pulse shows the position and polarity of that pulse
      if (busy_reg === 1'b1 && pulse_done === 1'b1 && sample_end === 1'b0)
         check(exp_pat.size() > 0 && {pulse_pos_reg, integ_reverse_reg} === exp_pat.pop_front(),
            "polarity pattern");
   end

   initial
   begin
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      rd(ICC_SLOT_A_POLARITY_ADDR);
      rd(ICC_SLOT_B_POLARITY_ADDR);
      rd(ICC_SIGN_MATH_ADDR);
      // Offset registers of both slots live outside this block and stay zero under chop mode
      for (i = 0; i < 4; i++)
      begin
         wr(8'(8'h18 + i), 16'h0000);
         wr(8'(8'h1e + i), 16'h0000);
      end
      rd(8'h18);
      wr(8'h40, 16'hffff);
      rd(8'h40);
      // Each pass sets a new code in every selector; the two slots never share one for the same pulse pair
      for (i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         wr(ICC_SLOT_A_POLARITY_ADDR, seed[15:0]);
         wr(ICC_SLOT_B_POLARITY_ADDR, seed[31:16]);
         wr(ICC_SIGN_MATH_ADDR, {4'h0, 2'(i + 2), 2'(i + 1), 1'b0, 2'(~i), 2'b00, 2'(i), seed[0]});
         rd(ICC_SLOT_A_POLARITY_ADDR);
         rd(ICC_SLOT_B_POLARITY_ADDR);
         rd(ICC_SIGN_MATH_ADDR);
         run(1'b0, 6 + 2 * i);
         run(1'b1, 16);
      end
      for (i = 0; i < 20 && exp_rd.size() + exp_sum.size() + exp_pat.size() > 0; i++) @(posedge clock);
      check(exp_rd.size() + exp_sum.size() + exp_pat.size() == 0, "results missing");
      test_done;
   end
endmodule

bind icc_chop_control icc_chop_control_assertions #(.DATA_W(DATA_W), .ACC_W(ACC_W)) u_chk (.clock, .reset_n, .reg_rd,
   .reg_rvalid_reg, .sample_start, .pulse_done, .sample_end, .integ_reverse_reg, .pulse_pos_reg, .sample_sum_reg,
   .sample_valid_reg, .busy_reg);
